// ===== rtl/glu_pkg.sv
// Constants, field layouts and carrier types for the glue-logic block.
// Assumes a 32-bit plain register port and a 10 MHz system clock.
package glu_pkg;

  // ==========================================================
  // Sizes
  localparam int NUM_LUT    = 2;
  localparam int LUT_INS    = 3;
  localparam int TRUTH_W    = 8;
  localparam int SEQ_SEL_W  = 4;
  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 32;

  // ==========================================================
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_SEQ_CTRL   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_UNIT_CTRL0 = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_STEP     = 8'h04;

  // ==========================================================
  // Field positions
  localparam int CTRL_SOFT_RST_BIT = 0;
  localparam int CTRL_EN_BIT       = 1;
  localparam int SEQ_SEL_LSB       = 0;
  localparam int LUT_EN_BIT     = 1;
  localparam int LUT_MASK_LSB   = 4;
  localparam int LUT_TRUTH_LSB  = 16;

  // ==========================================================
  // Reset values
  localparam logic                RST_BLK_EN = 1'b0;
  localparam logic [SEQ_SEL_W-1:0] RST_SEQ_SEL = 4'h0;
  localparam logic [TRUTH_W-1:0]  RST_TRUTH  = 8'h00;
  localparam logic [LUT_INS-1:0]  RST_MASK   = 3'h0;
  localparam logic [DATA_W-1:0]   RD_ZERO    = 32'h00000000;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              we;
    logic              re;
  } glu_req_t;

  typedef struct packed {
    logic [TRUTH_W-1:0] truth;
    logic [LUT_INS-1:0] mask;
    logic               en;
  } glu_lutcfg_t;

endpackage

// ===== rtl/glu_lut.sv
// One lookup-table unit: three maskable inputs into an 8-entry truth table.
// Assumes inputs are already synchronised; output is combinational.
`timescale 1ns/1ps
module glu_lut (
  // Configuration
  input  glu_pkg::glu_lutcfg_t        i_cfg,
  input  logic                        i_blk_en,
  // Data
  input  logic [glu_pkg::LUT_INS-1:0] i_in,
  output logic                        o_out
);

  // ==========================================================
  // Table lookup
  logic [glu_pkg::LUT_INS-1:0] idx;

  // Masked inputs read as zero so they cannot steer the result
  assign idx   = i_in & ~i_cfg.mask;
  assign o_out = i_cfg.en & i_blk_en & i_cfg.truth[idx];

endmodule

// ===== rtl/glu_top.sv
// Glue-logic block: register port, enable protection and lookup-table units.
// Assumes i_lut_in comes from pins (asynchronous) and the bus master is
// synchronous to i_clk with single-cycle strobes.
//
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/1ps
// How it works
// - A write to the sequential select field is taken only while the even unit of its pair is off.
// - Every field of a unit control register except its enable is written only while that unit is off.
// - Protected fields are taken in the write that turns the unit on, but not in one that turns it off.
// - Writing one to the block enable turns the block on, writing zero turns it off.
// - Each unit is turned on by writing one to its enable and off by writing zero.
// - Writing one to the soft reset bit returns all configuration registers to reset values and leaves the block off.
// - Each unit output is any Boolean function of three inputs given by its truth bits.
// - Any subset of a unit's three inputs can be masked out.
module glu_top #(
  parameter int NUM_LUT = glu_pkg::NUM_LUT
) (
  // Clock and reset
  input  logic                                i_clk,
  input  logic                                i_reset_n,
  // Register port
  input  glu_pkg::glu_req_t                   i_req,
  output logic [glu_pkg::DATA_W-1:0]          o_rdata,
  // Unit pins
  input  logic [NUM_LUT*glu_pkg::LUT_INS-1:0] i_lut_in,
  output logic [NUM_LUT-1:0]                  o_lut_out
);

  localparam int NUM_SEQ = NUM_LUT / 2;
  localparam int INS_W   = NUM_LUT * glu_pkg::LUT_INS;

  // ==========================================================
  // State
  typedef struct packed {
    logic                                        blk_en;
    logic [NUM_SEQ-1:0][glu_pkg::SEQ_SEL_W-1:0]  seq_sel;
    glu_pkg::glu_lutcfg_t [NUM_LUT-1:0]          lut;
    logic [INS_W-1:0]                            sync1;
    logic [INS_W-1:0]                            sync2;
    logic [NUM_LUT-1:0]                          out;
    logic [glu_pkg::DATA_W-1:0]                  rdata;
  } glu_state_t;

  glu_state_t         state_q;
  glu_state_t         state_d;
  glu_state_t         rst_val;
  logic [NUM_LUT-1:0] lut_res;

  // Address to unit decode, shared by read and write paths
  function automatic logic addr_is_lut(input logic [glu_pkg::ADDR_W-1:0] a, input int i);
    addr_is_lut = (a == glu_pkg::ADDR_W'(glu_pkg::OFS_UNIT_CTRL0 + i * glu_pkg::OFS_STEP));
  endfunction

  function automatic logic addr_is_seq(input logic [glu_pkg::ADDR_W-1:0] a, input int k);
    // Limitation: with four or more units this map overlaps the unit registers
    addr_is_seq = (a == glu_pkg::ADDR_W'(glu_pkg::OFS_SEQ_CTRL + k * glu_pkg::OFS_STEP * NUM_LUT));
  endfunction

  // Reset image, used only by the soft reset; the state register reset loads zeros
  always_comb begin
    rst_val        = '0;
    rst_val.blk_en = glu_pkg::RST_BLK_EN;
    for (int k = 0; k < NUM_SEQ; k++) begin
      rst_val.seq_sel[k] = glu_pkg::RST_SEQ_SEL;
    end
    for (int i = 0; i < NUM_LUT; i++) begin
      rst_val.lut[i].truth = glu_pkg::RST_TRUTH;
      rst_val.lut[i].mask  = glu_pkg::RST_MASK;
      rst_val.lut[i].en    = 1'b0;
    end
  end

  // ==========================================================
  // Units
  genvar g;
  generate
    for (g = 0; g < NUM_LUT; g++) begin : g_lut
      glu_lut u_lut (
        .i_cfg    (state_q.lut[g]),
        .i_blk_en (state_q.blk_en),
        .i_in     (state_q.sync2[g*glu_pkg::LUT_INS +: glu_pkg::LUT_INS]),
        .o_out    (lut_res[g])
      );
    end
  endgenerate

  // ==========================================================
  // Next state
  always_comb begin
    state_d       = state_q;
    // Pins cross two flops; only the second is read by logic
    state_d.sync1 = i_lut_in;
    state_d.sync2 = state_q.sync1;
    state_d.out   = lut_res;
    // Read data stands for one cycle only, so it falls back to zero by default
    state_d.rdata = glu_pkg::RD_ZERO;
    // Register writes
    if (i_req.we) begin
      if (i_req.addr == glu_pkg::OFS_CTRL) begin
        state_d.blk_en = i_req.wdata[glu_pkg::CTRL_EN_BIT];
      end
      for (int k = 0; k < NUM_SEQ; k++) begin
        // Sequencer pairs share the even unit's enable as their lock
        if (addr_is_seq(i_req.addr, k) && !state_q.lut[2*k].en) begin
          state_d.seq_sel[k] = i_req.wdata[glu_pkg::SEQ_SEL_LSB +: glu_pkg::SEQ_SEL_W];
        end
      end
      for (int i = 0; i < NUM_LUT; i++) begin
        if (addr_is_lut(i_req.addr, i)) begin
          state_d.lut[i].en = i_req.wdata[glu_pkg::LUT_EN_BIT];
          // Locked while running; the turn-on write still gets through
          if (!state_q.lut[i].en) begin
            state_d.lut[i].truth = i_req.wdata[glu_pkg::LUT_TRUTH_LSB +: glu_pkg::TRUTH_W];
            state_d.lut[i].mask  = i_req.wdata[glu_pkg::LUT_MASK_LSB +: glu_pkg::LUT_INS];
          end
        end
      end
      // Soft reset overrides everything in the same write
      // Sync flops are left alone: they hold pin levels, not configuration
      if (i_req.addr == glu_pkg::OFS_CTRL && i_req.wdata[glu_pkg::CTRL_SOFT_RST_BIT]) begin
        state_d.blk_en  = rst_val.blk_en;
        state_d.seq_sel = rst_val.seq_sel;
        state_d.lut    = rst_val.lut;
      end
    end
    // Register reads; soft reset bit self-clears so it reads zero
    if (i_req.re) begin
      if (i_req.addr == glu_pkg::OFS_CTRL) begin
        state_d.rdata[glu_pkg::CTRL_EN_BIT] = state_q.blk_en;
      end
      for (int k = 0; k < NUM_SEQ; k++) begin
        if (addr_is_seq(i_req.addr, k)) begin
          state_d.rdata[glu_pkg::SEQ_SEL_LSB +: glu_pkg::SEQ_SEL_W] = state_q.seq_sel[k];
        end
      end
      for (int i = 0; i < NUM_LUT; i++) begin
        if (addr_is_lut(i_req.addr, i)) begin
          state_d.rdata[glu_pkg::LUT_EN_BIT] = state_q.lut[i].en;
          state_d.rdata[glu_pkg::LUT_MASK_LSB +: glu_pkg::LUT_INS] = state_q.lut[i].mask;
          state_d.rdata[glu_pkg::LUT_TRUTH_LSB +: glu_pkg::TRUTH_W] = state_q.lut[i].truth;
        end
      end
    end
  end

  // State register, synchronous active-low reset
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign o_rdata   = state_q.rdata;
  assign o_lut_out = state_q.out;

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  logic wr_ctrl;
  logic wr_lut0;
  logic wr_seq0;
  logic [glu_pkg::LUT_INS-1:0] in0;
  assign wr_ctrl = i_req.we && i_req.addr == glu_pkg::OFS_CTRL;
  assign wr_lut0 = i_req.we && i_req.addr == glu_pkg::OFS_UNIT_CTRL0;
  assign wr_seq0 = i_req.we && i_req.addr == glu_pkg::OFS_SEQ_CTRL;
  assign in0     = state_q.sync2[glu_pkg::LUT_INS-1:0];

  // ==========================================================
  // Enable protection: only unit 0 and pair 0 are watched, the rest share the code
  seq_lock_a: assert property (wr_seq0 && state_q.lut[0].en |=> $stable(state_q.seq_sel[0]))
    else $error("sequencer select changed while even unit on");
  seq_open_a: assert property (wr_seq0 && !state_q.lut[0].en
      |=> state_q.seq_sel[0] == $past(i_req.wdata[glu_pkg::SEQ_SEL_LSB +: glu_pkg::SEQ_SEL_W]))
    else $error("sequencer select not taken while even unit off");
  lut_lock_a: assert property (wr_lut0 && state_q.lut[0].en
      |=> $stable(state_q.lut[0].truth) && $stable(state_q.lut[0].mask))
    else $error("unit config changed while unit on");
  turn_on_write_a: assert property (wr_lut0 && !state_q.lut[0].en
      && i_req.wdata[glu_pkg::LUT_EN_BIT] && !wr_ctrl
      |=> state_q.lut[0].truth == $past(i_req.wdata[glu_pkg::LUT_TRUTH_LSB +: glu_pkg::TRUTH_W]))
    else $error("turn-on write lost truth bits");

  // ==========================================================
  // Enables and soft reset
  blk_enable_a: assert property (wr_ctrl && !i_req.wdata[glu_pkg::CTRL_SOFT_RST_BIT]
      |=> state_q.blk_en == $past(i_req.wdata[glu_pkg::CTRL_EN_BIT]))
    else $error("block enable not taken");
  unit_enable_a: assert property (wr_lut0
      |=> state_q.lut[0].en == $past(i_req.wdata[glu_pkg::LUT_EN_BIT]))
    else $error("unit enable not taken");
  // Outputs lag the cleared state by one edge, hence the extra cycle
  soft_reset_a: assert property (wr_ctrl && i_req.wdata[glu_pkg::CTRL_SOFT_RST_BIT]
      |=> !state_q.blk_en && state_q.lut[0].truth == glu_pkg::RST_TRUTH ##1 o_lut_out == '0)
    else $error("soft reset left state");

  // ==========================================================
  // Data path and read port
  table_out_a: assert property (state_q.blk_en && state_q.lut[0].en
      |=> o_lut_out[0] == $past(state_q.lut[0].truth[in0 & ~state_q.lut[0].mask]))
    else $error("unit output wrong");
  mask_zero_a: assert property (state_q.blk_en && state_q.lut[0].en
      && state_q.lut[0].mask == 3'h7 |=> o_lut_out[0] == $past(state_q.lut[0].truth[0]))
    else $error("masked inputs steered output");
  off_zero_a: assert property (!state_q.blk_en || !state_q.lut[0].en |=> !o_lut_out[0])
    else $error("disabled unit drove one");
  read_idle_a: assert property (!i_req.re |=> o_rdata == glu_pkg::RD_ZERO)
    else $error("read data stood without a read strobe");

  // ==========================================================
  // Main scenarios
  unit_on_c:    cover property (wr_lut0 && i_req.wdata[glu_pkg::LUT_EN_BIT] ##1 o_lut_out[0]);
  locked_c:     cover property (wr_lut0 && state_q.lut[0].en);
  soft_rst_c:   cover property (wr_ctrl && i_req.wdata[glu_pkg::CTRL_SOFT_RST_BIT] && state_q.blk_en);
  unit_off_c:   cover property (wr_lut0 && state_q.lut[0].en && !i_req.wdata[glu_pkg::LUT_EN_BIT]);
  blk_resume_c: cover property (wr_ctrl && i_req.wdata[glu_pkg::CTRL_EN_BIT] && !state_q.blk_en);

endmodule

// ===== bench/tb_glu_top.sv
// Self-checking bench for the glue-logic block: register port tasks and unit output checks.
// Assumes the plain register port of glu_top and two units (NUM_LUT = 2).
`timescale 1ns/1ps
module tb_glu_top;
  // ==========================================================
  // Signals
  logic                       i_clk;
  logic                       i_reset_n;
  glu_pkg::glu_req_t          i_req;
  logic [31:0]                o_rdata;
  logic [5:0]                 i_lut_in;
  logic [1:0]                 o_lut_out;
  int                         bad_count;
  int                         cmp_count;

  `define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin bad_count++; \
    $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end

  glu_top #(.NUM_LUT(2)) uut (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_req     (i_req),
    .o_rdata   (o_rdata),
    .i_lut_in  (i_lut_in),
    .o_lut_out (o_lut_out)
  );

  // ==========================================================
  // Clock and verdict
  always #50 i_clk = ~i_clk;

  task automatic tally_and_finish();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ==========================================================
  // Register port tasks: one-cycle strobes, data read in the cycle after the strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge i_clk);
    i_req.we <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ex);
    @(posedge i_clk);
    i_req <= '{addr: a, wdata: 32'h00000000, we: 1'b0, re: 1'b1};
    @(posedge i_clk);
    i_req.re <= 1'b0;
    #1;
    `CHK("read data", ex, o_rdata)
  endtask

  // Walks all eight input codes of one unit; four edges cover the two sync flops and the output flop
  task automatic sweep(input int u, input logic [7:0] t, input logic [2:0] m, input logic on);
    logic [2:0] idx;
    for (int v = 0; v < 8; v++) begin
      @(posedge i_clk);
      i_lut_in[3*u +: 3] <= v[2:0];
      repeat (4) @(posedge i_clk);
      #1;
      idx = v[2:0] & ~m;
      `CHK("unit output", on & t[idx], o_lut_out[u])
    end
  endtask

  // ==========================================================
  // Watchdog: the sequence needs well under 3000 cycles
  initial begin
    repeat (6000) @(posedge i_clk);
    bad_count++;
    tally_and_finish();
  end

  // ==========================================================
  // Main sequence
  initial begin
    i_clk = 1'b0;
    i_reset_n = 1'b0;
    i_req = '0;
    i_lut_in = 6'h00;
    bad_count = 0;
    cmp_count = 0;
    repeat (20) @(posedge i_clk);
    i_reset_n <= 1'b1;
    for (int a = 0; a < 16; a += 4) begin
      rd(a[7:0], 32'h00000000);
    end
    rd(8'h40, 32'h00000000);
    // Select field open while unit 0 is off
    wr(8'h04, 32'h00000005);
    rd(8'h04, 32'h00000005);
    // Config taken in the same write that turns the unit on
    wr(8'h08, 32'h00960002);
    rd(8'h08, 32'h00960002);
    sweep(0, 8'h96, 3'h0, 1'b0);
    wr(8'h00, 32'h00000002);
    rd(8'h00, 32'h00000002);
    sweep(0, 8'h96, 3'h0, 1'b1);
    // Locked while unit 0 runs
    wr(8'h04, 32'h0000000A);
    rd(8'h04, 32'h00000005);
    wr(8'h08, 32'h00FF0072);
    rd(8'h08, 32'h00960002);
    // Turn-off write must not carry new config
    wr(8'h08, 32'h00FF0070);
    rd(8'h08, 32'h00960000);
    sweep(0, 8'h96, 3'h0, 1'b0);
    // Every mask code on unit 1
    for (int m = 0; m < 8; m++) begin
      wr(8'h0C, 32'h00000000);
      wr(8'h0C, 32'h00B40002 | (m << 4));
      rd(8'h0C, 32'h00B40002 | (m << 4));
      sweep(1, 8'hB4, m[2:0], 1'b1);
    end
    // Block off gates a running unit, block on resumes it; mask cleared so ones can show
    wr(8'h0C, 32'h00000000);
    wr(8'h0C, 32'h00B40002);
    wr(8'h00, 32'h00000000);
    sweep(1, 8'hB4, 3'h0, 1'b0);
    wr(8'h00, 32'h00000002);
    sweep(1, 8'hB4, 3'h0, 1'b1);
    // Soft reset wins over the enable in the same write
    wr(8'h00, 32'h00000003);
    for (int a = 0; a < 16; a += 4) begin
      rd(a[7:0], 32'h00000000);
    end
    `CHK("outputs after soft reset", 2'b00, o_lut_out)
    tally_and_finish();
  end
endmodule
